/* hw/cspc_core_ctrl.sv */
// Purpose: execution state, fetch alignment, decode selection and pipeline issue control
// Assumes: all inputs come from logic on the same core clock
// Notes: state changes arrive as one-cycle flow events from the execute stage
`default_nettype none

module cspc_core_ctrl
	import cspc_pkg::*;
#(
	parameter int FDEPTH = FETCH_DEPTH,
	parameter int MDEPTH = MISS_DEPTH
) (
	input wire logic clock, // core clock, 100 MHz
	input wire logic rstn, // async reset, active low
	input wire logic [31:0] reset_vector, // first fetch address after reset
	output logic fetch_req, // word fetch request, held until ack
	output logic [31:0] fetch_addr, // word-aligned fetch address
	input wire logic fetch_ack, // fetch data valid this cycle
	input wire logic [31:0] fetch_data, // fetched word
	output logic dec_valid, // decode slot holds an instruction
	output logic [31:0] dec_instr, // instruction, zero-extended when short
	output logic [31:0] dec_pc, // address of that instruction
	output logic [1:0] dec_state, // state it was fetched in
	input wire logic dec_ready, // decode slot consumed
	input wire logic flow_valid, // state-changing event this cycle
	input wire logic [2:0] flow_op, // kind of event
	input wire logic [31:0] flow_target, // branch target, vector or return address
	input wire logic [4:0] exc_mode, // mode entered on exception
	input wire logic bc_enable, // bytecode execution permitted
	input wire logic [7:0] bc_opcode, // bytecode sent to a handler
	input wire logic [31:0] bc_table_base, // handler table base from a general register
	input wire logic iss_valid, // instruction offered for issue
	input wire logic [2:0] iss_class, // class of offered instruction
	input wire logic [PASS_W-1:0] iss_passes, // multiply passes in stage one
	input wire logic [WORDS_W-1:0] iss_words, // words of a block transfer
	input wire logic iss_dep, // depends on a parked load
	output logic iss_ack, // offered instruction taken, pulse
	input wire logic dc_hit, // load in second cache stage hits
	input wire logic miss_fill, // one parked load refilled, pulse
	output logic alu_wb, // arithmetic write-back, pulse
	output logic mult_wb, // multiply write-back, pulse
	output logic ls_wb, // load/store write-back, pulse
	output logic miss_wb, // refilled load write-back, pulse
	output logic miss_busy, // miss buffer holds a load
	output logic [31:0] status_out, // current status register
	output logic [31:0] saved_out // saved status register
);
	localparam int MW = $clog2(MDEPTH + 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] cur_sr_q;
	logic [31:0] saved_sr_q;
	logic [31:0] fetch_pc_q;
	logic [31:0] fetch_addr_q;
	logic fetch_req_q;
	logic drop_q;
	logic [31:0] dec_ptr_q;
	logic dec_valid_q;
	logic [31:0] dec_instr_q;
	logic [31:0] dec_pc_q;
	logic [1:0] dec_state_q;
	logic boot_q;
	logic iss_ack_q;
	logic [ALU_STAGES-1:0] alu_pipe_q;
	logic [LS_STAGES-1:0] ls_pipe_q;
	logic [LS_STAGES-1:0] ls_ld_q;
	logic [WORDS_W-1:0] blk_cnt_q;
	logic [MW-1:0] miss_cnt_q;
	logic ls_wb_q;
	logic miss_wb_q;

	cspc_state_t cur_state;
	logic redirect;
	logic [31:0] new_sr;
	logic [31:0] new_saved;
	logic [31:0] new_pc;
	logic fetch_issue;
	logic buf_push;
	logic buf_pop;
	logic [31:0] buf_head;
	logic buf_empty;
	logic buf_full;
	logic dec_take;
	logic last_piece;
	logic [31:0] piece;
	logic [31:0] step;

	// ----------------------------------------------------------------
	// state change on flow events
	// ----------------------------------------------------------------
	assign cur_state = sr_state(cur_sr_q); // [RULE_20]
	assign redirect = flow_valid && (flow_op != FL_NONE);

	always_comb begin
		new_sr = cur_sr_q;
		new_saved = saved_sr_q;
		new_pc = flow_target;
		case (flow_op)
			FL_BX, FL_BLX, FL_LDPC: begin
				// only the state bits move; mode and registers stay put
				new_sr = sr_with_state(cur_sr_q, flow_target[0], 1'b0); // [RULE_11] [RULE_12]
				new_pc = {flow_target[31:1], 1'b0};
			end
			FL_BXJ: begin
				if (cur_state == ST_WIDE && bc_enable) begin
					new_sr = sr_with_state(cur_sr_q, 1'b0, 1'b1); // [RULE_13]
				end else begin
					// outside wide state or without permission it falls back to an ordinary exchange
					new_sr = sr_with_state(cur_sr_q, flow_target[0], 1'b0);
					new_pc = {flow_target[31:1], 1'b0};
				end
			end
			FL_EXC: begin
				new_saved = cur_sr_q;
				new_sr = sr_with_state(cur_sr_q, 1'b0, 1'b0); // [RULE_14]
				new_sr[SR_MODE_LSB +: SR_MODE_W] = exc_mode;
			end
			FL_ERET: begin
				new_sr = saved_sr_q; // [RULE_15]
			end
			FL_BCTRAP: begin
				// handler runs in wide state; saved copy lets it resume bytecodes
				new_saved = cur_sr_q;
				new_sr = sr_with_state(cur_sr_q, 1'b0, 1'b0); // [RULE_14]
				new_pc = bc_table_base + ({24'h0, bc_opcode} << BC_SLOT_SHIFT); // [RULE_17]
			end
			default: begin
				new_pc = flow_target;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cur_sr_q <= SR_RESET;
			saved_sr_q <= SR_RESET;
		end else if (redirect) begin
			cur_sr_q <= new_sr;
			saved_sr_q <= new_saved;
		end
	end

	// ----------------------------------------------------------------
	// fetch: always whole words, at most one request outstanding
	// ----------------------------------------------------------------
	assign fetch_issue = !fetch_req_q && !buf_full && !redirect && !boot_q;
	assign buf_push = fetch_req_q && fetch_ack && !drop_q && !redirect;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			boot_q <= 1'b1;
			fetch_pc_q <= '0;
			fetch_addr_q <= '0;
			fetch_req_q <= 1'b0;
			drop_q <= 1'b0;
		end else begin
			boot_q <= 1'b0;
			if (boot_q)
				fetch_pc_q <= {reset_vector[31:2], 2'b00};
			else if (redirect)
				fetch_pc_q <= {new_pc[31:2], 2'b00}; // [RULE_10]
			else if (fetch_issue)
				fetch_pc_q <= fetch_pc_q + WORD_STEP;
			if (fetch_issue) begin
				fetch_req_q <= 1'b1;
				fetch_addr_q <= fetch_pc_q; // [RULE_10]
			end else if (fetch_ack) begin
				fetch_req_q <= 1'b0;
			end
			// a word already in flight across a redirect belongs to the old stream
			if (fetch_req_q && fetch_ack)
				drop_q <= 1'b0;
			else if (redirect && fetch_req_q)
				drop_q <= 1'b1;
		end
	end

	cspc_fetch_buf #(
		.WIDTH(XLEN),
		.DEPTH(FDEPTH)
	) u_fetch_buf (
		.clock(clock),
		.rstn(rstn),
		.flush(redirect),
		.push(buf_push), // [RULE_19]
		.push_data(fetch_data),
		.pop(buf_pop),
		.head(buf_head),
		.empty(buf_empty),
		.full(buf_full)
	);

	// ----------------------------------------------------------------
	// decode selection by state
	// ----------------------------------------------------------------
	always_comb begin
		piece = buf_head;
		step = WORD_STEP;
		last_piece = 1'b1;
		case (cur_state)
			ST_WIDE: begin
				piece = buf_head; // [RULE_06]
				step = WORD_STEP;
				last_piece = 1'b1;
			end
			ST_COMPACT: begin
				// halfword goes down the same execute path as a wide instruction
				piece = {16'h0, dec_ptr_q[1] ? buf_head[31:16] : buf_head[15:0]}; // [RULE_09] [RULE_18]
				step = 32'h0000_0002; // [RULE_07]
				last_piece = dec_ptr_q[1];
			end
			ST_BYTECODE: begin
				// operand bytes follow their opcode one byte per slot
				piece = {24'h0, buf_head[{dec_ptr_q[1:0], 3'b000} +: 8]}; // [RULE_08] [RULE_16]
				step = 32'h0000_0001;
				last_piece = (dec_ptr_q[1:0] == 2'b11);
			end
			default: begin
				piece = buf_head;
				step = WORD_STEP;
				last_piece = 1'b1;
			end
		endcase
	end

	assign dec_take = !buf_empty && (!dec_valid_q || dec_ready) && !redirect;
	assign buf_pop = dec_take && last_piece;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dec_ptr_q <= '0;
			dec_valid_q <= 1'b0;
			dec_instr_q <= '0;
			dec_pc_q <= '0;
			dec_state_q <= ST_WIDE;
		end else if (boot_q) begin
			dec_ptr_q <= {reset_vector[31:2], 2'b00};
			dec_valid_q <= 1'b0;
		end else if (redirect) begin
			dec_ptr_q <= new_pc;
			dec_valid_q <= 1'b0;
		end else if (dec_take) begin
			dec_ptr_q <= dec_ptr_q + step;
			dec_valid_q <= 1'b1;
			dec_instr_q <= piece; // [RULE_20]
			dec_pc_q <= dec_ptr_q;
			dec_state_q <= cur_state;
		end else if (dec_ready) begin
			dec_valid_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// issue into the parallel pipelines
	// ----------------------------------------------------------------
	logic is_alu;
	logic is_mult;
	logic is_single;
	logic is_block;
	logic mult_busy;
	logic ls_free;
	logic [MW:0] ld_pending;
	logic miss_room;
	logic can_issue;
	logic take_iss;
	logic ls_inject;
	logic dc2_miss;

	assign is_alu = (iss_class == CL_ALU);
	assign is_mult = (iss_class == CL_MULT);
	assign is_single = (iss_class == CL_LOAD) || (iss_class == CL_STORE);
	assign is_block = (iss_class == CL_LDM) || (iss_class == CL_STM);
	assign ls_free = (blk_cnt_q == '0);
	assign ld_pending = (MW + 1)'(miss_cnt_q) + (MW + 1)'(ls_ld_q[0])
		+ (MW + 1)'(ls_ld_q[1]) + (MW + 1)'(ls_ld_q[2]);
	// counting loads still in the pipe keeps a late miss from overflowing
	assign miss_room = ld_pending < (MW + 1)'(MDEPTH);

	always_comb begin
		can_issue = 1'b0;
		if (is_alu)
			can_issue = 1'b1; // [RULE_03] [RULE_05]
		else if (is_mult)
			can_issue = !mult_busy;
		else if (is_single)
			can_issue = ls_free && miss_room && !(iss_dep && miss_cnt_q != '0); // [RULE_04]
		else if (is_block)
			can_issue = ls_free;
	end

	assign take_iss = iss_valid && !iss_ack_q && can_issue;
	assign ls_inject = (take_iss && is_single) || !ls_free;
	assign dc2_miss = ls_ld_q[LS_DC2] && !dc_hit;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			iss_ack_q <= 1'b0;
			alu_pipe_q <= '0;
			ls_pipe_q <= '0;
			ls_ld_q <= '0;
			blk_cnt_q <= '0;
		end else begin
			iss_ack_q <= take_iss;
			alu_pipe_q <= {alu_pipe_q[ALU_STAGES-2:0], take_iss && is_alu}; // [RULE_05]
			ls_pipe_q <= {ls_pipe_q[LS_STAGES-2:0], ls_inject};
			ls_ld_q <= {ls_ld_q[LS_STAGES-2:0], take_iss && iss_class == CL_LOAD};
			if (take_iss && is_block)
				blk_cnt_q <= (iss_words == '0) ? WORDS_W'(1) : iss_words; // [RULE_03]
			else if (!ls_free)
				blk_cnt_q <= blk_cnt_q - WORDS_W'(1); // [RULE_03]
		end
	end

	// ----------------------------------------------------------------
	// miss buffer and write-back
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			miss_cnt_q <= '0;
			ls_wb_q <= 1'b0;
			miss_wb_q <= 1'b0;
		end else begin
			if (dc2_miss && !(miss_fill && miss_cnt_q != '0))
				miss_cnt_q <= miss_cnt_q + MW'(1); // [RULE_04]
			else if (!dc2_miss && miss_fill && miss_cnt_q != '0)
				miss_cnt_q <= miss_cnt_q - MW'(1);
			ls_wb_q <= ls_pipe_q[LS_DC2] && !dc2_miss;
			miss_wb_q <= miss_fill && miss_cnt_q != '0;
		end
	end

	cspc_mult_pipe #(
		.PW(PASS_W)
	) u_mult (
		.clock(clock),
		.rstn(rstn),
		.start(take_iss && is_mult), // [RULE_01]
		.passes(iss_passes),
		.busy(mult_busy),
		.done(mult_wb)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign fetch_req = fetch_req_q;
	assign fetch_addr = fetch_addr_q;
	assign dec_valid = dec_valid_q;
	assign dec_instr = dec_instr_q;
	assign dec_pc = dec_pc_q;
	assign dec_state = dec_state_q;
	assign iss_ack = iss_ack_q;
	assign alu_wb = alu_pipe_q[ALU_STAGES-1];
	assign ls_wb = ls_wb_q;
	assign miss_wb = miss_wb_q;
	assign miss_busy = (miss_cnt_q != '0);
	assign status_out = cur_sr_q;
	assign saved_out = saved_sr_q;

endmodule

`default_nettype wire

/* hw/cspc_pkg.sv */
// Purpose: shared constants and types for the core state and pipeline control block
// Assumes: one core clock, asynchronous active-low reset
// Notes: status register layout and instruction classes are shared by the core control, checker and testbench files
// Function
// RULE_01: multiply loops in stage one until its requested passes are done.
// RULE_02: after looping, multiply passes once through stages two and three.
// RULE_03: block transfers occupy load/store pipe while arithmetic keeps issuing.
// RULE_04: parked load misses let later independent instructions and hitting loads continue.
// RULE_05: plain arithmetic uses only the arithmetic pipe.
// RULE_06: wide state executes word-aligned 32-bit instructions.
// RULE_07: compact state executes halfword-aligned 16-bit instructions.
// RULE_08: bytecode state executes byte-aligned variable-length bytecodes.
// RULE_09: compact state picks the halfword by program counter bit 1.
// RULE_10: bytecode state always fetches whole words.
// RULE_11: wide/compact switches keep operating mode and registers unchanged.
// RULE_12: branch-exchange, branch-link-exchange and PC loads switch wide/compact.
// RULE_13: bytecode state is entered from wide state only by branch-to-bytecode.
// RULE_14: exceptions return to wide state; handled and exited in wide state.
// RULE_15: exception return copies saved status into current status.
// RULE_16: simple stack bytecodes execute directly in hardware.
// RULE_17: complex bytecodes dispatch to handlers via a register-based table.
// RULE_18: compact instructions act exactly like their wide equivalents.
// RULE_19: fetch holds up to four instructions ahead of execution.
// RULE_20: current status holds the state; it steers fetch alignment and decode.
`default_nettype none

package cspc_pkg;

	localparam int XLEN = 32;

	typedef enum logic [1:0] {
		ST_WIDE = 2'h0,
		ST_COMPACT = 2'h1,
		ST_BYTECODE = 2'h2
	} cspc_state_t;

	typedef enum logic [2:0] {
		CL_ALU = 3'h0,
		CL_MULT = 3'h1,
		CL_LOAD = 3'h2,
		CL_STORE = 3'h3,
		CL_LDM = 3'h4,
		CL_STM = 3'h5
	} cspc_class_t;

	typedef enum logic [2:0] {
		FL_NONE = 3'h0,
		FL_BX = 3'h1,
		FL_BLX = 3'h2,
		FL_LDPC = 3'h3,
		FL_BXJ = 3'h4,
		FL_EXC = 3'h5,
		FL_ERET = 3'h6,
		FL_BCTRAP = 3'h7
	} cspc_flow_t;

	// ----------------------------------------------------------------
	// status register layout
	// ----------------------------------------------------------------
	localparam int SR_MODE_LSB = 0;
	localparam int SR_MODE_W = 5;
	localparam int SR_T_BIT = 5;
	localparam int SR_J_BIT = 24;
	localparam logic [31:0] SR_RESET = 32'h0000_01D3;

	// ----------------------------------------------------------------
	// pipeline geometry
	// ----------------------------------------------------------------
	localparam int FETCH_DEPTH = 4;
	localparam int ALU_STAGES = 4;
	localparam int LS_STAGES = 3;
	localparam int LS_DC2 = 2;
	localparam int MISS_DEPTH = 2;
	localparam int PASS_W = 3;
	localparam int WORDS_W = 4;
	localparam int BC_SLOT_SHIFT = 2;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;

	function automatic cspc_state_t sr_state(input logic [31:0] sr);
		if (sr[SR_J_BIT])
			return ST_BYTECODE;
		else if (sr[SR_T_BIT])
			return ST_COMPACT;
		else
			return ST_WIDE;
	endfunction

	function automatic logic [31:0] sr_with_state(input logic [31:0] sr, input logic t,
		input logic j);
		logic [31:0] r;
		r = sr;
		r[SR_T_BIT] = t;
		r[SR_J_BIT] = j;
		return r;
	endfunction

endpackage

`default_nettype wire

/* hw/cspc_fetch_buf.sv */
// Purpose: small flop queue holding fetched words ahead of decode
// Assumes: push and pop may happen in the same cycle; flush wins over both
// Notes: storage is flip-flops addressed by index
`default_nettype none

module cspc_fetch_buf #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input wire logic clock, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic flush, // drop all entries
	input wire logic push, // write one entry
	input wire logic [WIDTH-1:0] push_data, // entry to write
	input wire logic pop, // consume head
	output logic [WIDTH-1:0] head, // oldest entry
	output logic empty, // no entry held
	output logic full // no room left
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] rd_q;
	logic [AW-1:0] wr_q;
	logic [CW-1:0] cnt_q;
	logic do_push;
	logic do_pop;

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign empty = (cnt_q == '0);
	assign full = (cnt_q == CW'(DEPTH));
	assign head = mem_q[rd_q];
	assign do_push = push && !full;
	assign do_pop = pop && !empty;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_q <= '0;
			wr_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			rd_q <= '0;
			wr_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push)
				wr_q <= nxt(wr_q);
			if (do_pop)
				rd_q <= nxt(rd_q);
			if (do_push && !do_pop)
				cnt_q <= cnt_q + CW'(1);
			else if (do_pop && !do_push)
				cnt_q <= cnt_q - CW'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (do_push)
			mem_q[wr_q] <= push_data;
	end

endmodule

`default_nettype wire

/* hw/cspc_mult_pipe.sv */
// Purpose: multiply-accumulate stage sequencing with looping first stage
// Assumes: start only while busy is low
// Notes: a pass count of zero is treated as one pass
`default_nettype none

module cspc_mult_pipe
	import cspc_pkg::*;
#(
	parameter int PW = PASS_W
) (
	input wire logic clock, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic start, // multiply enters stage one
	input wire logic [PW-1:0] passes, // passes needed in stage one
	output logic busy, // stage one occupied
	output logic done // result formed, one-cycle pulse
);
	logic s1_q;
	logic [PW-1:0] loop_q;
	logic s2_q;
	logic s3_q;
	logic done_q;
	logic s1_leave;

	assign s1_leave = s1_q && (loop_q <= PW'(1));
	assign busy = s1_q;
	assign done = done_q;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s1_q <= 1'b0;
			loop_q <= '0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			if (start) begin
				s1_q <= 1'b1;
				loop_q <= passes;
			end else if (s1_leave) begin
				s1_q <= 1'b0;
			end else if (s1_q) begin
				loop_q <= loop_q - PW'(1); // [RULE_01]
			end
			s2_q <= s1_leave; // [RULE_02]
			s3_q <= s2_q; // [RULE_02]
			done_q <= s3_q;
		end
	end

endmodule

`default_nettype wire

/* verif/cspc_checker.sv */
// Purpose: concurrent checks on the core control ports
// Assumes: one core clock, rstn asynchronous active low
// Notes: attached to every core control instance by bind
`default_nettype none

module cspc_checker
	import cspc_pkg::*;
(
	input wire logic clock, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic fetch_req, // fetch request
	input wire logic [31:0] fetch_addr, // fetch address
	input wire logic flow_valid, // flow event
	input wire logic [2:0] flow_op, // flow kind
	input wire logic [31:0] flow_target, // flow target
	input wire logic [4:0] exc_mode, // exception mode
	input wire logic bc_enable, // bytecode permit
	input wire logic iss_ack, // issue taken
	input wire logic [2:0] iss_class, // issue class
	input wire logic [PASS_W-1:0] iss_passes, // multiply passes
	input wire logic [WORDS_W-1:0] iss_words, // block words
	input wire logic dc_hit, // cache hit
	input wire logic alu_wb, // alu write-back
	input wire logic mult_wb, // multiply write-back
	input wire logic ls_wb, // load/store write-back
	input wire logic miss_busy, // miss buffer busy
	input wire logic [31:0] status_out, // current status
	input wire logic [31:0] saved_out // saved status
);
	// --------------------------------
	// checks
	// --------------------------------
	wire [4:0] mode_w = status_out[SR_MODE_LSB +: SR_MODE_W];
	wire wide_w = !status_out[SR_T_BIT] && !status_out[SR_J_BIT];
	// exception return may restore bytecode state
	wire j_ok = flow_valid && (flow_op == FL_ERET || (flow_op == FL_BXJ && bc_enable && wide_w));
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	a_fetch_word_aligned: assert property (fetch_req |-> fetch_addr[1:0] == 2'h0)
		else $error("fetch unaligned");
	a_exc_to_wide: assert property (flow_valid && flow_op == FL_EXC |=> wide_w
		&& mode_w == $past(exc_mode) && saved_out == $past(status_out))
		else $error("exception entry");
	a_eret_restores: assert property (flow_valid && flow_op == FL_ERET
		|=> status_out == $past(saved_out)) else $error("exception return");
	a_exchange_keeps_mode: assert property (flow_valid
		&& flow_op inside {FL_BX, FL_BLX, FL_LDPC}
		|=> status_out[SR_T_BIT] == $past(flow_target[0]) && mode_w == $past(mode_w))
		else $error("exchange");
	a_bytecode_entry: assert property ($rose(status_out[SR_J_BIT]) |-> $past(j_ok))
		else $error("bytecode entry");
	a_alu_wb_time: assert property (iss_ack && $past(iss_class) == CL_ALU |-> ##3 alu_wb)
		else $error("alu wb late");
	a_mult_single: assert property (iss_ack && $past(iss_class) == CL_MULT
		&& $past(iss_passes) <= 3'h1 |-> ##3 mult_wb) else $error("multiply late");
	a_mult_loops: assert property (iss_ack && $past(iss_class) == CL_MULT
		&& $past(iss_passes) == 3'h3 |-> !mult_wb ##5 mult_wb) else $error("multiply loop");
	a_block_words: assert property (iss_ack && $past(iss_class) == CL_LDM
		&& $past(iss_words) == 4'h4 |-> ##4 ls_wb [*4]) else $error("block wb");
	a_load_hit_wb: assert property (iss_ack && $past(iss_class) == CL_LOAD ##2 dc_hit
		|=> ls_wb) else $error("load hit wb");
	c_exception: cover property (flow_valid && flow_op == FL_EXC);
	c_miss_park: cover property ($rose(miss_busy));
	c_bytecode: cover property ($rose(status_out[SR_J_BIT]));
endmodule

bind cspc_core_ctrl cspc_checker chk_u (.clock, .rstn, .fetch_req, .fetch_addr, .flow_valid,
	.flow_op, .flow_target, .exc_mode, .bc_enable, .iss_ack, .iss_class, .iss_passes,
	.iss_words, .dc_hit, .alu_wb, .mult_wb, .ls_wb, .miss_busy, .status_out, .saved_out);

`default_nettype wire

/* verif/cspc_fetch_model.sv */
// Purpose: instruction memory answering word fetches
// Assumes: one request outstanding, held until acknowledged
// Notes: latency alternates between prompt and slow; byte at address b holds b[7:0]
`default_nettype none

module cspc_fetch_model (
	input wire logic clock, // core clock
	input wire logic fetch_req, // word request
	input wire logic [31:0] fetch_addr, // word address
	output logic fetch_ack, // data valid
	output logic [31:0] fetch_data // fetched word
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------------------------------
	// responder
	// --------------------------------
	int wait_n = 0;
	bit slow = 0;
	wire [7:0] b = fetch_addr[7:0];
	initial begin
		fetch_ack = 1'b0;
		fetch_data = 32'h0000_0000;
	end
	// released data is inverted so a stale word never looks valid
	always @(negedge clock) begin
		if (fetch_ack) begin
			fetch_ack <= 1'b0;
			fetch_data <= ~fetch_data;
		end else if (fetch_req && wait_n > 0) begin
			wait_n <= wait_n - 1;
		end else if (fetch_req) begin
			fetch_ack <= 1'b1;
			fetch_data <= {b + 8'h3, b + 8'h2, b + 8'h1, b};
			wait_n <= slow ? 2 : 0;
			slow <= !slow;
		end
	end
endmodule

`default_nettype wire

/* verif/testbench.sv */
// Purpose: self-checking bench for the core state and pipeline control
// Assumes: inputs change at the falling clock edge
// Notes: fetch side is the memory model; decode, flow and issue are driven here
`default_nettype none

module testbench;
	import cspc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rstn = 0, fetch_req, fetch_ack, dec_valid, dec_ready = 0, iss_ack;
	logic [31:0] reset_vector = 32'h0000_0200, fetch_addr, fetch_data, dec_instr, dec_pc;
	logic [31:0] flow_target = 0, bc_table_base = 0, status_out, saved_out;
	logic [1:0] dec_state;
	logic [2:0] flow_op = 0, iss_class = 0, iss_passes = 0;
	logic [3:0] iss_words = 0;
	logic [4:0] exc_mode = 5'h17;
	logic [7:0] bc_opcode = 0;
	logic flow_valid = 0, bc_enable = 1, iss_valid = 0, iss_dep = 0, dc_hit = 1, miss_fill = 0;
	logic alu_wb, mult_wb, ls_wb, miss_wb, miss_busy;
	int fails = 0, n_compared = 0, nacks = 0, nls = 0;
	cspc_core_ctrl dut_u (.clock, .rstn, .reset_vector, .fetch_req, .fetch_addr, .fetch_ack,
		.fetch_data, .dec_valid, .dec_instr, .dec_pc, .dec_state, .dec_ready, .flow_valid,
		.flow_op, .flow_target, .exc_mode, .bc_enable, .bc_opcode, .bc_table_base, .iss_valid,
		.iss_class, .iss_passes, .iss_words, .iss_dep, .iss_ack, .dc_hit, .miss_fill, .alu_wb,
		.mult_wb, .ls_wb, .miss_wb, .miss_busy, .status_out, .saved_out);
	cspc_fetch_model mem_u (.clock, .fetch_req, .fetch_addr, .fetch_ack, .fetch_data);
	initial forever #5 clock = ~clock;
	always @(posedge clock) begin
		nacks += (fetch_req && fetch_ack);
		nls += (ls_wb === 1'b1);
	end
	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic [31:0] ew(input logic [31:0] a);
		return {a[7:0] + 8'h3, a[7:0] + 8'h2, a[7:0] + 8'h1, a[7:0]};
	endfunction
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			fails++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	task automatic flow(input logic [2:0] op, input logic [31:0] t);
		flow_op = op;
		flow_target = t;
		flow_valid = 1;
		@(negedge clock);
		flow_valid = 0;
		@(negedge clock);
	endtask
	task automatic dec(input logic [31:0] pc, input logic [31:0] ins, input logic [1:0] st);
		int k;
		for (k = 0; k < 40 && dec_valid !== 1'b1; k++) @(negedge clock);
		chk(dec_pc === pc && dec_instr === ins && dec_state === st, "decode slot mismatch");
		dec_ready = 1;
		@(negedge clock);
		dec_ready = 0;
		@(negedge clock);
	endtask
	task automatic iss(input logic [2:0] c, input logic [2:0] p, input logic [3:0] w,
		output int k);
		iss_class = c;
		iss_passes = p;
		iss_words = w;
		iss_valid = 1;
		for (k = 0; k < 30 && iss_ack !== 1'b1; k++) @(negedge clock);
		iss_valid = 0;
		@(negedge clock);
	endtask
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_fetch;
		repeat (40) @(negedge clock);
		chk(nacks == 5, "fetch depth");
		dec(32'h0000_0200, ew(32'h0000_0200), ST_WIDE);
		dec(32'h0000_0204, ew(32'h0000_0204), ST_WIDE);
	endtask
	task automatic t_states;
		flow(FL_BLX, 32'h0000_0101);
		chk(status_out[SR_T_BIT] === 1'b1 && status_out[4:0] === 5'h13, "compact entry");
		dec(32'h0000_0100, 32'h0000_0100, ST_COMPACT);
		dec(32'h0000_0102, 32'h0000_0302, ST_COMPACT);
		flow(FL_BXJ, 32'h0000_0301);
		chk(status_out[SR_J_BIT] === 1'b0, "bytecode entered from compact");
		flow(FL_LDPC, 32'h0000_0300);
		flow(FL_BXJ, 32'h0000_0305);
		chk(status_out[SR_J_BIT] === 1'b1, "bytecode not entered");
		dec(32'h0000_0305, 32'h0000_0005, ST_BYTECODE);
		dec(32'h0000_0306, 32'h0000_0006, ST_BYTECODE);
		bc_opcode = 8'h10;
		bc_table_base = 32'h0000_1000;
		flow(FL_BCTRAP, 32'h0000_0000);
		dec(32'h0000_1040, ew(32'h0000_1040), ST_WIDE);
		flow(FL_ERET, 32'h0000_0307);
		dec(32'h0000_0307, 32'h0000_0007, ST_BYTECODE);
		flow(FL_EXC, 32'h0000_0010);
		chk(status_out[4:0] === 5'h17 && saved_out[SR_J_BIT] === 1'b1, "exception save");
		dec(32'h0000_0010, ew(32'h0000_0010), ST_WIDE);
	endtask
	task automatic t_pipes;
		int k, n;
		logic [2:0] pl[2] = '{3'h3, 3'h0};
		iss(CL_ALU, 0, 0, k);
		n = 0;
		repeat (4) begin
			@(negedge clock);
			n += (ls_wb !== 1'b0 || miss_busy !== 1'b0);
		end
		chk(k == 1 && n == 0, "alu used other pipes");
		foreach (pl[i]) begin
			iss(CL_MULT, pl[i], 0, k);
			for (k = 0; k < 20 && mult_wb !== 1'b1; k++) @(negedge clock);
			chk(k == ((pl[i] == 0) ? 1 : pl[i]) + 1, "multiply timing");
			repeat (4) @(negedge clock);
		end
		nls = 0;
		iss(CL_LDM, 0, 4, k);
		iss(CL_ALU, 0, 0, k);
		chk(k == 1, "alu blocked");
		repeat (8) @(negedge clock);
		chk(nls == 4, "block write-back count");
		dc_hit = 0;
		iss(CL_LOAD, 0, 0, k);
		repeat (3) @(negedge clock);
		chk(miss_busy === 1'b1, "miss not parked");
		dc_hit = 1;
		nls = 0;
		iss(CL_LOAD, 0, 0, k);
		repeat (3) @(negedge clock);
		chk(nls == 1 && miss_busy === 1'b1, "hit load did not pass miss");
		miss_fill = 1;
		@(negedge clock);
		miss_fill = 0;
		chk(miss_wb === 1'b1, "refill write-back missing");
		@(negedge clock);
		chk(miss_busy === 1'b0, "miss buffer not emptied");
	endtask
	task automatic summarize;
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clock);
		rstn = 1;
		t_fetch();
		t_states();
		t_pipes();
		summarize();
	end
	// whole run needs well under a thousand cycles
	initial begin
		#50us;
		fails++;
		summarize();
	end
endmodule

`default_nettype wire
